// >>> src/sdram_mode_dll_off_control.sv
/*
  Mode-register behaviour of the memory device: second and third mode
  registers, command decode with no-operation and deselect, DLL-off
  operation, read and write latency timing and a Wishbone status port.
  Assumes command pins are driven by the controller on clk_i itself.
*/
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_dll_off_control (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Command pins from the controller
  input  wire sdram_mode_pkg::cmd_pins_type cmd_i,
  // Register bus
  input  wire sdram_mode_pkg::wb_req_type   wb_i,
  output      sdram_mode_pkg::wb_rsp_type   wb_o,
  // Datapath timing
  output logic                             read_strobe_o,
  output logic                             read_from_pattern_o,
  output logic [7:0]                       read_pattern_o,
  output logic [1:0]                       pattern_sel_o,
  output logic                             write_capture_o,
  // Refresh, termination and DLL state
  output logic [7:0]                       refresh_bank_mask_o,
  output logic                             refresh_rate_ext_o,
  output logic [1:0]                       rtt_wr_o,
  output logic                             self_refresh_o,
  output logic                             dll_enabled_o,
  output logic                             dll_locked_o
);
  import sdram_mode_pkg::*;

  typedef struct packed {
    logic [3:0][13:0] mr;
    logic             sr;
    logic [9:0]       lock_cnt;
    logic             locked;
    logic [7:0]       lost;
    logic             illegal;
    logic             hot;
    logic             ack;
    logic [31:0]      rdat;
  } state_type;

  state_type st;
  state_type next_st;

  // ==========================================================
  // Command decode
  logic sel, mrs_cmd, ref_cmd, rd_cmd, wr_cmd, other_cmd;
  assign sel       = !cmd_i.cs_n;
  assign mrs_cmd   = sel && !cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
  assign ref_cmd   = sel && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
  assign rd_cmd    = sel && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n && !st.sr;
  assign wr_cmd    = sel && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n && !st.sr;
  // Anything selected that is not a no-operation
  assign other_cmd = sel && !(cmd_i.ras_n && cmd_i.cas_n && cmd_i.we_n);

  // ==========================================================
  // Mode fields and effective latencies
  logic       dll_off, pat_en, wlevel, sr_entry, sr_exit;
  logic [4:0] cl_prog, wcas_prog, cl, write_cas_delay, al, wl, rl;
  logic [2:0] partial_array_refresh;
  logic [7:0] bank_mask;
  assign dll_off  = st.mr[1][MR1_DLL_OFF];
  assign pat_en   = st.mr[3][MR3_PAT_EN];
  assign wlevel   = st.mr[1][MR1_WLEVEL];
  assign partial_array_refresh = st.mr[2][MR2_KEEP_LSB +: 3];
  assign cl_prog  = 5'(st.mr[0][MR0_CL_LSB +: 3]) + CL_BASE;
  assign wcas_prog = 5'(st.mr[2][MR2_WCAS_LSB +: 3]) + WCAS_BASE;
  // DLL-off has a single latency pair, both six
  assign cl       = dll_off ? DLL_OFF_LAT : cl_prog;
  assign write_cas_delay = dll_off ? DLL_OFF_LAT : wcas_prog;

  always_comb begin
    case (st.mr[1][MR1_AL_LSB +: 2])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;  // Disabled, and the reserved code
    endcase
  end

  assign wl = al + write_cas_delay;
  // DLL-off reads launch one edge earlier
  assign rl = al + cl - (dll_off ? 5'h01 : 5'h00);

  // Kept part of the array per partial refresh code
  always_comb begin
    case (partial_array_refresh)
      3'h1:    bank_mask = 8'h0F;
      3'h2:    bank_mask = 8'h03;
      3'h3:    bank_mask = 8'h01;
      3'h4:    bank_mask = 8'hFC;
      3'h5:    bank_mask = 8'hF0;
      3'h6:    bank_mask = 8'hC0;
      3'h7:    bank_mask = 8'h80;
      default: bank_mask = 8'hFF;
    endcase
  end

  // Self refresh starts on refresh with clock enable low, ends on it rising
  assign sr_entry = ref_cmd && !cmd_i.cke && !st.sr;
  assign sr_exit  = st.sr && cmd_i.cke;

  // ==========================================================
  // Register bus decode
  logic        wb_hit, wb_wr, wb_rd;
  logic [31:0] status, rd_val;
  assign wb_hit = wb_i.cyc && wb_i.stb && !st.ack;
  assign wb_wr  = wb_hit && wb_i.we && wb_i.sel[0];
  assign wb_rd  = wb_hit && !wb_i.we;
  assign status = {16'h0000, st.lost, 1'b0, st.illegal, refresh_rate_ext_o,
                   wlevel, pat_en, st.sr, st.locked, dll_enabled_o};

  always_comb begin
    if (wb_i.adr == CTRL_OFS) begin
      rd_val = {31'h0, st.hot};
    end else if (wb_i.adr == STATUS_OFS) begin
      rd_val = status;
    end else if (wb_i.adr == LATENCY_OFS) begin
      rd_val = {17'h0, rl, wl, cl};
    end else if (wb_i.adr[7:4] == MR_BASE_OFS[7:4] && wb_i.adr[1:0] == 2'h0) begin
      rd_val = {18'h0, st.mr[wb_i.adr[3:2]]};
    end else begin
      rd_val = 32'h0000_0000;  // Unmapped reads answer zero
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    // Reset bit is visible one cycle, then drops by itself
    next_st.mr[0][MR0_DLL_RESET] = 1'b0;
    // Apart from the self-clearing reset bit, only a register set aimed at a register changes it
    if (mrs_cmd && !st.sr) begin
      next_st.mr[cmd_i.ba[1:0]] = cmd_i.addr;
    end
    if (sr_entry) begin
      next_st.sr = 1'b1;
    end else if (sr_exit) begin
      next_st.sr = 1'b0;
    end
    // Rows outside the kept range are gone once self refresh starts
    if (sr_entry) begin
      next_st.lost = st.lost | ~bank_mask;
    end
    // Lock counts while the DLL is on and unlocked, restarting at a DLL reset; DLL-off or self refresh drops it
    if (st.mr[0][MR0_DLL_RESET] && !dll_off) begin
      next_st.lock_cnt = 10'h000;
      next_st.locked   = 1'b0;
    end else if (dll_off || st.sr) begin
      next_st.lock_cnt = 10'h000;
      next_st.locked   = 1'b0;
    end else if (!st.locked && st.lock_cnt != DLL_LOCK_CYCLES) begin
      next_st.lock_cnt = st.lock_cnt + 10'h001;
    end else begin
      next_st.locked = 1'b1;
    end
    // Software writes: sensor stand-in, write-one-to-clear flags
    if (wb_wr && wb_i.adr == CTRL_OFS) begin
      next_st.hot = wb_i.dat[CTRL_HOT_BIT];
    end
    if (wb_wr && wb_i.adr == STATUS_OFS) begin
      next_st.illegal = st.illegal & ~wb_i.dat[STAT_ILLEGAL];
      if (wb_i.sel[1]) begin
        next_st.lost = next_st.lost & ~wb_i.dat[STAT_LOST_LSB +: 8];
      end
    end
    // A forbidden command in pattern mode is flagged; set wins over clear
    if (pat_en && other_cmd && !rd_cmd && !mrs_cmd) begin
      next_st.illegal = 1'b1;
    end
    if (sr_entry) begin  // Entry beats a clear in the same cycle
      next_st.lost = next_st.lost | ~bank_mask;
    end
    // Ack for one cycle, then drop
    next_st.ack = wb_hit;
    if (wb_rd) begin
      next_st.rdat = rd_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{mr: {4{MR_RESET}}, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Read and write timing lines; pattern mode tags each read
  logic rd_tag;

  latency_line #(.W(1), .DEPTH(LAT_DEPTH)) u_read_line (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (rd_cmd),
    .lat_i   (rl),
    .tag_i   (pat_en),
    .pulse_o (read_strobe_o),
    .tag_o   (rd_tag)
  );

  latency_line #(.W(1), .DEPTH(LAT_DEPTH)) u_write_line (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (wr_cmd),
    .lat_i   (wl),
    .tag_i   (1'b0),
    .pulse_o (write_capture_o),
    .tag_o   ()
  );

  // ==========================================================
  // Outputs
  assign read_from_pattern_o = read_strobe_o && rd_tag;
  assign read_pattern_o      = read_from_pattern_o ? CAL_PATTERN : 8'h00;
  // Select bits mean nothing while the pattern is off
  assign pattern_sel_o       = pat_en ? st.mr[3][MR3_PAT_SEL +: 2] : 2'h0;
  assign refresh_bank_mask_o = bank_mask;
  // Thermal sensor overrides the programmed rate in auto mode
  assign refresh_rate_ext_o  = st.mr[2][MR2_AUTO_RATE] ? st.hot
                                                       : st.mr[2][MR2_EXT_RATE];
  // Write leveling leaves only nominal termination
  assign rtt_wr_o            = wlevel ? 2'h0 : st.mr[2][MR2_RTT_WR_LSB +: 2];
  assign self_refresh_o      = st.sr;
  assign dll_enabled_o       = !dll_off && !st.sr;
  assign dll_locked_o        = st.locked;
  // One driver for the whole response word
  assign wb_o                = '{ack: st.ack, dat: st.rdat};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_dll_reset;
    mrs_cmd && !st.sr && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[MR0_DLL_RESET];
  endsequence

  sequence s_reset_seen;
    st.mr[0][MR0_DLL_RESET] ##1 !st.mr[0][MR0_DLL_RESET];
  endsequence

  property p_mr3_load;
    mrs_cmd && !st.sr && cmd_i.ba == 3'h3 |=> st.mr[3] == $past(cmd_i.addr);
  endproperty
  a_mr3_load: assert property (p_mr3_load) else $error("third register not loaded");

  property p_dll_reset_clear;
    s_dll_reset |=> s_reset_seen;
  endproperty
  a_dll_reset_clear: assert property (p_dll_reset_clear) else $error("reset bit stuck");

  property p_no_change;
    !mrs_cmd |=> st.mr[3:1] == $past(st.mr[3:1]);
  endproperty
  a_no_change: assert property (p_no_change) else $error("mode field changed");

  property p_write_lat;
    wr_cmd && wl == 5'h06 |-> ##6 write_capture_o;
  endproperty
  a_write_lat: assert property (p_write_lat) else $error("write latency wrong");

  property p_dll_off_read;
    rd_cmd && dll_off && al == 5'h00 |-> ##5 read_strobe_o;
  endproperty
  a_dll_off_read: assert property (p_dll_off_read) else $error("DLL-off read time");

  property p_pattern_read;
    rd_cmd && pat_en && rl == 5'h05 |-> ##5 read_from_pattern_o && read_pattern_o == CAL_PATTERN;
  endproperty
  a_pattern_read: assert property (p_pattern_read) else $error("pattern not used");

  property p_auto_rate;
    st.mr[2][MR2_AUTO_RATE] |-> refresh_rate_ext_o == st.hot;
  endproperty
  a_auto_rate: assert property (p_auto_rate) else $error("rate source wrong");

  property p_rtt_level;
    wlevel |-> rtt_wr_o == 2'h0;
  endproperty
  a_rtt_level: assert property (p_rtt_level) else $error("write termination in leveling");

  property p_lost;
    sr_entry && partial_array_refresh != 3'h0 |=> st.lost != 8'h00 && st.sr;
  endproperty
  a_lost: assert property (p_lost) else $error("lost rows not flagged");

  property p_deselect;
    cmd_i.cs_n |=> !$rose(st.illegal) && $stable(st.mr[3:1]);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect acted");
endmodule // sdram_mode_dll_off_control
`default_nettype wire

// >>> inc/sdram_mode_pkg.sv
/*
  Constants, field positions and carrier types for the mode-register,
  calibration-pattern and DLL-off control block of a DDR3 memory device.
  Assumes one command clock shared with the controller and a Wishbone
  classic master for the status and control registers.
*/
package sdram_mode_pkg;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [2:0]  ba;
    logic [13:0] addr;
  } cmd_pins_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_type;

  // ==========================================================
  // Mode register fields (address pin positions)
  localparam int MR0_CL_LSB     = 4;
  localparam int MR0_DLL_RESET  = 8;
  localparam int MR1_DLL_OFF    = 0;
  localparam int MR1_AL_LSB     = 3;
  localparam int MR1_WLEVEL     = 7;
  localparam int MR2_KEEP_LSB   = 0;
  localparam int MR2_WCAS_LSB   = 3;
  localparam int MR2_AUTO_RATE  = 6;
  localparam int MR2_EXT_RATE   = 7;
  localparam int MR2_RTT_WR_LSB = 9;
  localparam int MR3_PAT_SEL    = 0;
  localparam int MR3_PAT_EN     = 2;
  localparam logic [13:0] MR_RESET = 14'h0000;

  // ==========================================================
  // Latency constants, in clock cycles, and the calibration pattern
  localparam logic [4:0] CL_BASE     = 5'h04;
  localparam logic [4:0] WCAS_BASE   = 5'h05;
  localparam logic [4:0] DLL_OFF_LAT = 5'h06;
  localparam int         LAT_DEPTH   = 32;
  localparam logic [9:0] DLL_LOCK_CYCLES = 10'h200;
  localparam logic [7:0] CAL_PATTERN = 8'h55;

  // ==========================================================
  // Wishbone register map (byte addresses)
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] LATENCY_OFS = 8'h08;
  localparam logic [7:0] MR_BASE_OFS = 8'h20;
  localparam int CTRL_HOT_BIT  = 0;
  localparam int STAT_ILLEGAL  = 6;
  localparam int STAT_LOST_LSB = 8;

endpackage

// >>> src/latency_line.sv
/*
  Variable-latency pulse line: a start pulse with a latency L comes out
  exactly L cycles later together with its tag.
  Assumes latency is at least 1 and below DEPTH; a later start that lands
  on an occupied slot merges into it.
*/
`timescale 1ns/1ps
`default_nettype none
module latency_line #(
  parameter int W     = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Start side
  input  wire logic         start_i,
  input  wire logic [4:0]   lat_i,
  input  wire logic [W-1:0] tag_i,
  // Delayed side
  output logic              pulse_o,
  output logic [W-1:0]      tag_o
);
  typedef struct packed {
    logic [DEPTH-1:0]        v;
    logic [DEPTH-1:0][W-1:0] tag;
  } line_type;

  line_type st;
  line_type next_st;
  logic [DEPTH-1:0]        shift_v;
  logic [DEPTH-1:0][W-1:0] shift_tag;

  // ==========================================================
  // Each slot either takes a new start or the slot above it
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    logic hit;
    assign hit = start_i && (lat_i == 5'(i + 1));
    if (i == DEPTH - 1) begin : g_top
      assign shift_v[i]   = hit;
      assign shift_tag[i] = hit ? tag_i : '0;
    end else begin : g_mid
      assign shift_v[i]   = hit | st.v[i+1];
      assign shift_tag[i] = hit ? tag_i : st.tag[i+1];
    end
  end

  always_comb begin
    next_st.v   = shift_v;
    next_st.tag = shift_tag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_o = st.v[0];
  assign tag_o   = st.tag[0];
endmodule // latency_line
`default_nettype wire

// >>> verification/ddr_ctrl_model.sv
/*
  Behavioural memory controller that drives the command pins of the
  mode-register block: mode register sets, reads, writes, no-operation,
  self refresh and the two DLL switching procedures.
  Assumes the device samples the pins on the rising edge of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model #(
  parameter int T_MOD   = 12,
  parameter int T_MRD   = 4,
  parameter int T_CKSRE = 10,
  parameter int T_CKSRX = 10,
  parameter int T_XS    = 20,
  parameter int T_ZQOPER = 64
) (
  // Clock
  input  wire logic                        clk_i,
  // Command pins toward the device
  output var  sdram_mode_pkg::cmd_pins_type cmd_o
);
  import sdram_mode_pkg::*;

  // ==========================================================
  // Pin driving
  // Deselected with clock enable high from time zero
  initial cmd_o = {4'hF, 1'h1, 3'h0, 14'h0000};

  // One command cycle, then deselect with toggled lines so stale values never look valid
  task automatic drive(input logic [3:0] s, input logic k, input logic [2:0] b,
                       input logic [13:0] a);
    @(posedge clk_i);
    cmd_o <= {s, k, b, a};
    @(posedge clk_i);
    cmd_o <= {4'hF, k, ~b, ~a};
  endtask

  // ==========================================================
  // Commands
  task automatic mrs(input logic [1:0] b, input logic [13:0] a);
    drive(4'h0, 1'h1, {1'h0, b}, a);
  endtask
  // Reserved bits and BA2 held at zero
  task automatic mr3(input logic [2:0] a);
    mrs(2'h3, {11'h000, a});
  endtask
  // Only reads and mode register sets may be issued while the pattern is on, as a write is flagged; banks are never opened
  task automatic rd();
    drive(4'h5, 1'h1, 3'h0, 14'h0000);
  endtask
  task automatic wr();
    drive(4'h4, 1'h1, 3'h0, 14'h0000);
  endtask
  task automatic nop();
    drive(4'h7, 1'h1, 3'h0, 14'h0000);
  endtask
  // Enter or leave self refresh; the clock may only change while inside
  task automatic sref(input logic enter);
    if (enter) begin
      drive(4'h1, 1'h0, 3'h0, 14'h0000);
      repeat (T_CKSRE + T_CKSRX) @(posedge clk_i);
    end else begin
      drive(4'h7, 1'h1, 3'h0, 14'h0000);
      repeat (T_XS) @(posedge clk_i);
    end
  endtask

  // ==========================================================
  // DLL switching procedures
  task automatic dll_off();
    mrs(2'h1, 14'h0001);
    repeat (T_MOD) @(posedge clk_i);
    sref(1'h1);
    sref(1'h0);
    mrs(2'h0, 14'h0020);
    mrs(2'h2, 14'h0008);
    repeat (T_MOD) @(posedge clk_i);
  endtask
  task automatic dll_on();
    sref(1'h1);
    sref(1'h0);
    mrs(2'h1, 14'h0000);
    repeat (T_MRD) @(posedge clk_i);
    mrs(2'h0, 14'h0100);
    repeat (T_MRD) @(posedge clk_i);
    mrs(2'h0, 14'h0010);
    repeat (T_MOD) @(posedge clk_i);
    // Long impedance calibration, then its full operation time before use
    drive(4'h6, 1'h1, 3'h0, 14'h0400);
    repeat (T_ZQOPER) @(posedge clk_i);
  endtask
endmodule  // ddr_ctrl_model
`default_nettype wire

// >>> verification/test_sdram_mode_dll_off_control.sv
/*
  Self-checking bench for the mode-register block: a row table over the
  second mode register, then hand tests for latency, pattern mode, no-op,
  deselect and DLL switching. Assumes ddr_ctrl_model drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_dll_off_control;
  import sdram_mode_pkg::*;

  typedef struct packed {
    logic [13:0] a;
    logic        hot;
    logic [7:0]  mask;
    logic        rate;
    logic [1:0]  rtt;
    logic [4:0]  wl;
  } row_type;

  logic         clk_i, rst_i;
  cmd_pins_type cmd_i;
  wb_req_type   wb_i;
  wb_rsp_type   wb_o;
  logic         read_strobe_o, read_from_pattern_o, write_capture_o;
  logic [7:0]   read_pattern_o, refresh_bank_mask_o;
  logic [1:0]   pattern_sel_o, rtt_wr_o;
  logic         refresh_rate_ext_o, self_refresh_o, dll_enabled_o, dll_locked_o;
  logic         pf;
  logic [7:0]   pv;
  logic [31:0]  q;
  int           errors, n_compared, cycles, n;
  row_type rows[8] = '{
    '{14'h0000, 1'h0, 8'hFF, 1'h0, 2'h0, 5'h05}, '{14'h0289, 1'h0, 8'h0F, 1'h1, 2'h1, 5'h06},
    '{14'h0452, 1'h0, 8'h03, 1'h0, 2'h2, 5'h07}, '{14'h06DB, 1'h0, 8'h01, 1'h0, 2'h3, 5'h08},
    '{14'h0024, 1'h1, 8'hFC, 1'h0, 2'h0, 5'h09}, '{14'h02AD, 1'h1, 8'hF0, 1'h1, 2'h1, 5'h0A},
    '{14'h0476, 1'h1, 8'hC0, 1'h1, 2'h2, 5'h0B}, '{14'h06FF, 1'h1, 8'h80, 1'h1, 2'h3, 5'h0C}};

  // ==========================================================
  // Design, controller model, clock
  sdram_mode_dll_off_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
    .wb_i(wb_i), .wb_o(wb_o), .read_strobe_o(read_strobe_o),
    .read_from_pattern_o(read_from_pattern_o), .read_pattern_o(read_pattern_o),
    .pattern_sel_o(pattern_sel_o), .write_capture_o(write_capture_o),
    .refresh_bank_mask_o(refresh_bank_mask_o), .refresh_rate_ext_o(refresh_rate_ext_o),
    .rtt_wr_o(rtt_wr_o), .self_refresh_o(self_refresh_o), .dll_enabled_o(dll_enabled_o),
    .dll_locked_o(dll_locked_o));
  ddr_ctrl_model i_ctrl (.clk_i(clk_i), .cmd_o(cmd_i));
  // 200 MHz command clock
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single cycle; ack sampled at the edge, then release; only the timeout ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_o.ack !== 1'h1);
    q = wb_o.dat;
    wb_i <= '0;
  endtask
  // Cycles from the command cycle to the strobe; a no-op may follow the command
  task automatic lat(input logic r, input logic busy);
    if (r) i_ctrl.rd();
    else i_ctrl.wr();
    n = 1;
    if (busy) begin
      i_ctrl.nop();
      n = 3;
    end
    #1;
    while (((r ? read_strobe_o : write_capture_o) !== 1'h1) && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    pf = read_from_pattern_o;
    pv = read_pattern_o;
  endtask
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Timeout: generous over the roughly 1000 cycles of the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'h1;
    wb_i = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    chk("mask_reset", 32'hFF, refresh_bank_mask_o);
    chk("dll_reset", 32'h1, dll_enabled_o);
    wb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    // Row table: partial refresh, write delay, rate select, termination
    foreach (rows[i]) begin
      wb(1'h1, CTRL_OFS, {31'h0, rows[i].hot});
      i_ctrl.mrs(2'h2, rows[i].a);
      #1;
      chk("mask", rows[i].mask, refresh_bank_mask_o);
      chk("rate_ext", rows[i].rate, refresh_rate_ext_o);
      chk("rtt_wr", rows[i].rtt, rtt_wr_o);
      lat(1'h0, 1'h0);
      chk("write_lat", rows[i].wl, n);
      wb(1'h0, MR_BASE_OFS + 8'h08, 32'h0);
      chk("mr2_image", rows[i].a, q);
    end
    // Additive latency: CL 5, AL = CL-1, write CAS delay 5
    i_ctrl.mrs(2'h2, 14'h0400);
    i_ctrl.mrs(2'h0, 14'h0010);
    i_ctrl.mrs(2'h1, 14'h0008);
    lat(1'h1, 1'h1);
    chk("read_lat_al", 32'd9, n);
    lat(1'h0, 1'h0);
    chk("write_lat_al", 32'd9, n);
    wb(1'h0, LATENCY_OFS, 32'h0);
    chk("latency_reg", 32'h2525, q);
    // Write leveling forces nominal termination only
    i_ctrl.mrs(2'h1, 14'h0080);
    #1;
    chk("rtt_level", 32'h0, rtt_wr_o);
    i_ctrl.mrs(2'h1, 14'h0000);
    #1;
    chk("rtt_back", 32'h2, rtt_wr_o);
    // No-op and deselect with mode-set strobes change nothing
    i_ctrl.nop();
    i_ctrl.drive(4'h8, 1'h1, 3'h2, 14'h3FFF);
    #1;
    chk("no_strobe", 32'h0, read_strobe_o | write_capture_o);
    wb(1'h0, MR_BASE_OFS + 8'h08, 32'h0);
    chk("mr2_desel", 32'h400, q);
    // Calibration pattern on, then off with select bits ignored
    i_ctrl.mr3(3'h6);
    #1;
    chk("pat_sel", 32'h2, pattern_sel_o);
    lat(1'h1, 1'h0);
    chk("pat_read", 32'h155, {pf, pv});
    // A write in pattern mode is flagged; the flag clears by writing one
    i_ctrl.wr();
    wb(1'h0, STATUS_OFS, 32'h0);
    chk("illegal_set", 32'h1, q[STAT_ILLEGAL]);
    wb(1'h1, STATUS_OFS, 32'h0000_0040);
    wb(1'h0, STATUS_OFS, 32'h0);
    chk("illegal_clear", 32'h0, q[STAT_ILLEGAL]);
    wb(1'h0, MR_BASE_OFS + 8'h0C, 32'h0);
    chk("mr3_image", 32'h6, q);
    i_ctrl.mr3(3'h3);
    #1;
    chk("pat_off_sel", 32'h0, pattern_sel_o);
    lat(1'h1, 1'h0);
    chk("array_read", 32'h000, {pf, pv});
    // DLL off through self refresh with partial refresh of bank 0 only
    i_ctrl.mrs(2'h2, 14'h0003);
    i_ctrl.dll_off();
    chk("dll_off", 32'h0, dll_enabled_o);
    lat(1'h1, 1'h0);
    chk("read_lat_off", 32'd5, n);
    lat(1'h0, 1'h0);
    chk("write_lat_off", 32'd6, n);
    wb(1'h0, STATUS_OFS, 32'h0);
    chk("lost_banks", 32'hFE, q[15:8]);
    wb(1'h1, STATUS_OFS, 32'h0000FF00);
    wb(1'h0, STATUS_OFS, 32'h0);
    chk("lost_clear", 32'h0, q[15:8]);
    // DLL back on with reset; reset bit clears itself, lock follows
    i_ctrl.dll_on();
    chk("dll_on", 32'h1, dll_enabled_o);
    // A reset bit written with the latency must be gone when read back
    i_ctrl.mrs(2'h0, 14'h0110);
    wb(1'h0, MR_BASE_OFS, 32'h0);
    chk("dll_reset_bit", 32'h10, q);
    chk("unlocked", 32'h0, dll_locked_o);
    n = 0;
    while (dll_locked_o !== 1'h1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk("locked", 32'h1, dll_locked_o);
    // Self refresh shows on its pin and stops the DLL
    i_ctrl.drive(4'h1, 1'h0, 3'h0, 14'h0000);
    #1;
    chk("sr_in", 32'h1, self_refresh_o);
    chk("sr_dll", 32'h0, dll_enabled_o);
    i_ctrl.sref(1'h0);
    chk("sr_out", 32'h0, self_refresh_o);
    // Mid-run reset drops every mode field and the lock
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, MR_BASE_OFS, 32'h0);
    chk("mr0_reset", 32'h0, q);
    chk("lock_reset", 32'h0, dll_locked_o);
    end_of_test();
  end
endmodule  // test_sdram_mode_dll_off_control
`default_nettype wire
